// >>> core/isp_programmer.sv
/*
  Programmer end: on a command pulse sends one four-byte instruction,
  making SCK from clk, and returns the byte seen during the fourth byte
  and the echo of the second, seen during the third. Also performs the power-up reset sequence.
*/
`timescale 1ns/1ps
module isp_programmer
  import isp_pkg::*;
#(
  parameter int POWERUP_WAIT = POWERUP_WAIT_CYC
) (
  input  wire logic        clk,
  input  wire logic        reset,
  isp_link_if.programmer   link,
  input  wire logic        session,
  input  wire logic        cmd_valid,
  input  wire logic [31:0] cmd_word,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_data,
  output logic [7:0]       rsp_echo
);
  typedef enum logic [3:0] {
    P_OFF   = 4'b0001,
    P_PULSE = 4'b0010,
    P_WAIT  = 4'b0100,
    P_READY = 4'b1000
  } pstate_t;

  // ===========================================================
  // Power-up: SCK low and reset high until session, a short further high pulse, then reset low for 20 ms
  pstate_t     ps_q;
  logic [23:0] pw_q;
  logic        rst_n_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ps_q    <= P_OFF;
      pw_q    <= 24'h0;
      rst_n_q <= 1'b1;
    end else begin
      case (ps_q)
        P_OFF: if (session) begin
          ps_q    <= P_PULSE;
          rst_n_q <= 1'b1;
          pw_q    <= 24'(RESET_PULSE_CYC);
        end
        P_PULSE: begin
          pw_q <= pw_q - 24'd1;
          if (pw_q == 24'd1) begin
            rst_n_q <= 1'b0;
            ps_q    <= P_WAIT;
            pw_q    <= 24'(POWERUP_WAIT);
          end
        end
        P_WAIT: begin
          pw_q <= pw_q - 24'd1;
          if (pw_q == 24'd1) ps_q <= P_READY;
        end
        P_READY: if (!session) begin
          rst_n_q <= 1'b1;
          ps_q    <= P_OFF;
        end
        default: ps_q <= P_OFF;
      endcase
    end
  end
  assign link.rst_n = rst_n_q;

  // ===========================================================
  // Shifter: SCK phases of SCK_HALF_CYC clocks each
  logic        miso_s0_q, miso_s1_q;
  logic [31:0] tx_q;
  logic [7:0]  rx_q;
  logic [5:0]  nbit_q;
  logic [2:0]  div_q;
  logic        sck_q, busy_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      miso_s0_q <= 1'b0;
      miso_s1_q <= 1'b0;
    end else begin
      miso_s0_q <= link.miso;
      miso_s1_q <= miso_s0_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_q      <= 32'h0;
      rx_q      <= 8'h00;
      nbit_q    <= 6'd0;
      div_q     <= 3'd0;
      sck_q     <= 1'b0;
      busy_q    <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 8'h00;
      rsp_echo  <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      if (!busy_q) begin
        if (cmd_valid && cmd_ready && ps_q == P_READY) begin
          tx_q   <= cmd_word;
          busy_q <= 1'b1;
          nbit_q <= 6'd0;
          div_q  <= 3'd0;
        end
      end else if (div_q == 3'(SCK_HALF_CYC - 1)) begin
        div_q <= 3'd0;
        sck_q <= ~sck_q;
        // Sampled just before the fall: the round trip through both synchronisers
        // outlasts a low phase, so the bit launched at the last fall settles only now
        if (sck_q) begin
          rx_q   <= {rx_q[6:0], miso_s1_q};
          tx_q   <= {tx_q[30:0], 1'b0};
          nbit_q <= nbit_q + 6'd1;
          if (nbit_q == 6'd23) rsp_echo <= {rx_q[6:0], miso_s1_q};
          if (nbit_q == 6'd31) begin
            busy_q    <= 1'b0;
            rsp_valid <= 1'b1;
            rsp_data  <= {rx_q[6:0], miso_s1_q};
          end
        end
      end else begin
        div_q <= div_q + 3'd1;
      end
    end
  end
  assign link.sck  = sck_q;
  assign link.mosi = tx_q[31];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) cmd_ready <= 1'b0;
    else cmd_ready <= (ps_q == P_READY) && !busy_q && !(cmd_valid && cmd_ready);
  end
endmodule : isp_programmer

// >>> core/isp_target.sv
/*
  Device end of the serial programming port: shifts four-byte instructions,
  executes them against Flash, EEPROM, fuse, lock and signature storage.
  Assumes link pins are asynchronous to clk and sampled here.
*/
`timescale 1ns/1ps
module isp_target
  import isp_pkg::*;
#(
  parameter int FLASH_WAIT = FLASH_WAIT_CYC,
  parameter int EE_WAIT    = EE_WAIT_CYC,
  parameter int ERASE_WAIT = ERASE_WAIT_CYC
) (
  input  wire logic  clk,
  input  wire logic  reset,
  isp_link_if.target link,
  output logic       prog_mode,
  output logic       busy
);
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BUSY  = 3'b010,
    ST_ERASE = 3'b100
  } mem_state_t;

  // ===========================================================
  // Pin synchronisers
  logic [1:0] rst_s_q, sck_s_q, mosi_s_q;
  logic       sck_d1_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rst_s_q  <= 2'h3;
      sck_s_q  <= 2'h0;
      mosi_s_q <= 2'h0;
      sck_d1_q <= 1'b0;
    end else begin
      rst_s_q  <= {rst_s_q[0], link.rst_n};
      sck_s_q  <= {sck_s_q[0], link.sck};
      mosi_s_q <= {mosi_s_q[0], link.mosi};
      sck_d1_q <= sck_s_q[1];
    end
  end
  wire in_reset = ~rst_s_q[1];
  wire sck_rise = sck_s_q[1] & ~sck_d1_q;
  wire sck_fall = ~sck_s_q[1] & sck_d1_q;

  // ===========================================================
  // Storage
  logic [7:0] flash_q [2**(FLASH_WORD_BITS+1)];
  logic [7:0] ee_q    [2**EE_ADDR_BITS];
  logic [7:0] page_q  [2**(PAGE_WORD_BITS+1)];
  logic [7:0] fuse_lo_q, fuse_hi_q, lock_q;
  logic [7:0] sig_q   [4];
  localparam logic [7:0] SIG_MAKER_ID = 8'h5A; // Arbitrary value, names no maker
  assign sig_q[0] = SIG_MAKER_ID; // Remaining identity bytes arbitrary too
  assign sig_q[1] = 8'h01;
  assign sig_q[2] = 8'h02;
  assign sig_q[3] = 8'h03;

  // ===========================================================
  // Serial shifter and two-entry instruction buffer
  logic [31:0] shift_q;
  logic [4:0]  bit_q;
  logic [7:0]  out_q;
  logic [31:0] fifo_q [2];
  logic        wr_q, rd_q;
  logic [1:0]  cnt_q;
  logic        enabled_q;
  wire         in_valid = sck_rise & (bit_q == 5'd31);
  wire         in_ready = (cnt_q != 2'd2);
  wire         ex_valid = (cnt_q != 2'd0);
  mem_state_t  st_q;
  wire         ex_ready = (st_q == ST_IDLE);
  wire  [31:0] ins = fifo_q[rd_q];
  wire  [31:0] next_word = {shift_q[30:0], mosi_s_q[1]};

  function automatic logic is_enable(input logic [15:0] hi);
    is_enable = (hi[15:8] == OP_ENABLE) && (hi[7:0] == ENABLE_ECHO);
  endfunction : is_enable

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      shift_q <= 32'h0;
      bit_q   <= 5'd0;
    end else if (!in_reset) begin
      shift_q <= 32'h0;
      bit_q   <= 5'd0;
    end else if (sck_rise) begin
      shift_q <= next_word;
      bit_q   <= bit_q + 5'd1;
    end
  end

  logic [7:0] busy_page_q;
  logic [8:0] busy_ee_q;
  logic       ee_busy_q;

  // Read answer computed on the last rise of the third byte, with that bit included
  logic [7:0] rd_data;
  always_comb begin
    logic [13:0] fw;
    logic [8:0]  ea;
    fw = next_word[13:0];
    ea = next_word[8:0];
    rd_data = 8'h00;
    // H bit masked only for program reads: other opcodes differ in that bit
    if (enabled_q && (next_word[23:16] & H_BIT_MASK) == OP_READ_PROG) begin
      rd_data = (st_q == ST_BUSY && !ee_busy_q && fw[13:6] == busy_page_q) ? ERASED
                : flash_q[{fw, next_word[19]}];
    end else if (enabled_q) begin
      case (next_word[23:16])
        OP_READ_EE:   rd_data = (st_q == ST_BUSY && ee_busy_q && ea == busy_ee_q) ? ERASED
                                : ee_q[ea];
        OP_READ_LOCK: rd_data = (next_word[15:8] == 8'h08) ? fuse_hi_q : lock_q;
        OP_READ_FUSE: rd_data = fuse_lo_q;
        OP_READ_SIG:  rd_data = sig_q[next_word[1:0]];
        OP_READ_CAL:  rd_data = CAL_VALUE;
        default:      rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      out_q <= 8'h00;
    end else if (!in_reset) begin
      out_q <= 8'h00;
    end else if (sck_rise && bit_q == 5'd15) begin
      out_q <= next_word[7:0];
    end else if (sck_rise && bit_q == 5'd23) begin
      out_q <= rd_data;
    end
  end
  // MISO picks the bit of the current slot on each falling edge
  logic miso_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) miso_q <= 1'b0;
    else if (sck_fall) miso_q <= out_q[~bit_q[2:0]];
  end
  assign link.miso = miso_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      enabled_q <= 1'b0;
    end else if (!in_reset) begin
      enabled_q <= 1'b0;
    end else if (in_valid && is_enable(next_word[31:16])) begin
      enabled_q <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (in_valid && in_ready && enabled_q) begin
        fifo_q[wr_q] <= next_word;
        wr_q         <= ~wr_q;
      end
      if (ex_valid && ex_ready) rd_q <= ~rd_q;
      cnt_q <= cnt_q + 2'((in_valid && in_ready && enabled_q) ? 1 : 0)
                     - 2'((ex_valid && ex_ready) ? 1 : 0);
    end
  end

  // ===========================================================
  // Execution
  logic [23:0] wait_q;
  logic [14:0] clr_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_q        <= ST_IDLE;
      wait_q      <= 24'h0;
      busy_page_q <= 8'h00;
      busy_ee_q   <= 9'h0;
      ee_busy_q   <= 1'b0;
      clr_q       <= 15'h0;
      fuse_lo_q   <= FUSE_LO_RESET;
      fuse_hi_q   <= FUSE_HI_RESET;
      lock_q      <= LOCK_RESET;
    end else begin
      case (st_q)
        ST_IDLE: if (ex_valid) begin
          ee_busy_q <= 1'b0;
          if (ins[31:24] == OP_ENABLE && ins[23:21] == SUB_ERASE) begin
            st_q   <= ST_ERASE;
            clr_q  <= 15'h0;
            wait_q <= 24'(ERASE_WAIT);
            lock_q <= LOCK_RESET;
          end else if (ins[31:24] == OP_ENABLE && ins[23:21] == SUB_LOCK) begin
            lock_q <= lock_q & {2'h3, ins[5:0]};
          end else if (ins[31:24] == OP_ENABLE && ins[23:16] == SUB_FUSE_LO) begin
            fuse_lo_q <= ins[7:0];
          end else if (ins[31:24] == OP_ENABLE && ins[23:16] == SUB_FUSE_HI) begin
            fuse_hi_q <= ins[7:0];
          end else if ((ins[31:24] & H_BIT_MASK) == OP_LOAD_PAGE) begin
            page_q[{ins[13:8], ins[27]}] <= ins[7:0];
          end else if (ins[31:24] == OP_WRITE_PAGE) begin
            busy_page_q <= {ins[21:16], ins[15:14]};
            for (int i = 0; i < 2**(PAGE_WORD_BITS+1); i++)
              flash_q[{ins[21:16], ins[15:14], 7'(i)}] <= page_q[i];
            st_q   <= ST_BUSY;
            wait_q <= 24'(FLASH_WAIT);
          end else if (ins[31:24] == OP_WRITE_EE) begin
            ee_q[{ins[16], ins[15:8]}] <= ins[7:0];
            busy_ee_q <= {ins[16], ins[15:8]};
            ee_busy_q <= 1'b1;
            st_q      <= ST_BUSY;
            wait_q    <= 24'(EE_WAIT);
          end
        end
        ST_BUSY: begin
          wait_q <= wait_q - 24'd1;
          if (wait_q <= 24'd1) st_q <= ST_IDLE;
        end
        ST_ERASE: begin
          flash_q[clr_q] <= ERASED;
          if (clr_q < 15'(2**EE_ADDR_BITS)) ee_q[clr_q[8:0]] <= ERASED;
          // Both counters hold at their end, so neither can wrap and hang the erase
          if (!(&clr_q)) clr_q <= clr_q + 15'd1;
          if (wait_q != 24'h0) wait_q <= wait_q - 24'd1;
          if (wait_q <= 24'd1 && &clr_q) st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prog_mode <= 1'b0;
      busy      <= 1'b0;
    end else begin
      prog_mode <= enabled_q;
      busy      <= (st_q != ST_IDLE);
    end
  end
endmodule : isp_target

// >>> dv/isp_link_properties.sv
/*
  Checker for the link between programmer and target.
  Assumes it is instantiated beside the interface, on the shared clk.
*/
`timescale 1ns/1ps
module isp_link_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic prog_mode,
  input wire logic busy
);
  // ====================
  // Link timing
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Phases over 3 clocks at 50 MHz, so at least 4 samples
  chk_sck_high_min: assert property ($rose(sck) |-> sck[*4])
    else $error("sck high phase too short");
  chk_sck_low_min: assert property ($fell(sck) |-> !sck[*4])
    else $error("sck low phase too short");
  chk_mosi_at_rise: assert property (sck |-> $stable(mosi))
    else $error("mosi moved while sck high");
  chk_miso_when_low: assert property (!rst_n && $changed(miso) |-> !sck)
    else $error("miso moved while sck high");
  chk_sck_in_reset: assert property (sck |-> !rst_n)
    else $error("sck toggles outside session");
  chk_rst_pulse_len: assert property ($rose(rst_n) |-> rst_n[*2])
    else $error("reset pulse shorter than two clocks");
  // ====================
  // Mode tracking
  chk_enable_in_rst: assert property ($rose(prog_mode) |-> !rst_n)
    else $error("programming mode entered without reset low");
  chk_exit_on_rst: assert property (rst_n[*5] |-> !prog_mode)
    else $error("programming mode kept after reset release");
  chk_busy_in_prog: assert property ($rose(busy) |-> prog_mode)
    else $error("busy without programming mode");
  cov_enable: cover property ($rose(prog_mode));
  cov_write_done: cover property ($fell(busy));
  cov_frame: cover property (prog_mode && $rose(sck));
endmodule : isp_link_properties

// >>> dv/test_serial_isp_programming_port.sv
/*
  Bench joining programmer and target; drives the command side.
  Assumes shortened target waits and a 50 MHz clock.
*/
`timescale 1ns/1ps
module test_serial_isp_programming_port;
  import isp_pkg::*;
  typedef struct {logic [7:0] d; logic [7:0] e; bit cd; bit ce;} note_t;
  logic        clk, reset, session, cmd_valid, cmd_ready, rsp_valid, prog_mode, busy;
  logic [31:0] cmd_word;
  logic [7:0]  rsp_data, rsp_echo, v, w, p;
  logic [8:0]  a;
  logic [5:0]  wd;
  int          miscompares, n_compared;
  note_t       q[$];
  note_t       n;
  isp_link_if link();
  // Waits long enough that a read right after a write lands inside it
  isp_target #(.FLASH_WAIT(600), .EE_WAIT(600), .ERASE_WAIT(40000)) i_isp_target (
    .clk(clk), .reset(reset), .link(link), .prog_mode(prog_mode), .busy(busy));
  isp_programmer #(.POWERUP_WAIT(100)) i_isp_programmer (
    .clk(clk), .reset(reset), .link(link), .session(session), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_echo(rsp_echo));
  isp_link_properties i_isp_link_properties (
    .clk(clk), .reset(reset), .rst_n(link.rst_n), .sck(link.sck), .mosi(link.mosi),
    .miso(link.miso), .prog_mode(prog_mode), .busy(busy));
  // ====================
  // Tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic send(input logic [31:0] word, input logic [7:0] d, input bit cd, input bit ce);
    int   t;
    logic r;
    t = 0;
    q.push_back('{d, ENABLE_ECHO, cd, ce});
    cmd_word = word;
    cmd_valid = 1'b1;
    // Ready read while settled, before the edge that takes the command
    do begin
      r = cmd_ready;
      @(posedge clk);
      #1;
      t++;
    end while (r !== 1'b1 && t < 3000);
    cmd_valid = 1'b0;
    if (r !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t command never taken", $time);
    end
    repeat (260) @(posedge clk);
    #1;
  endtask : send
  task automatic rd(input logic [31:0] word, input logic [7:0] exp);
    send(word, exp, 1'b1, 1'b0);
  endtask : rd
  task automatic wait_idle();
    int t;
    t = 0;
    while (busy !== 1'b0 && t < 50000) begin
      @(posedge clk);
      #1;
      t++;
    end
    if (busy !== 1'b0) begin
      miscompares++;
      $display("[ERR] %0t busy never cleared", $time);
    end
  endtask : wait_idle
  task automatic wrd(input logic [31:0] wword, input logic [31:0] rword, input logic [7:0] exp);
    send(wword, 8'h00, 1'b0, 1'b0);
    wait_idle();
    rd(rword, exp);
  endtask : wrd
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  // ====================
  // Clock, watchdog, response monitor
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #2000000;
    miscompares++;
    wrap_up();
  end
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      if (q.size() == 0) begin
        miscompares++;
        $display("[ERR] %0t response without a note", $time);
      end else begin
        n = q.pop_front();
        if (n.ce) check(rsp_echo, n.e);
        if (n.cd) check(rsp_data, n.d);
      end
    end
  end
  // ====================
  // Tests
  initial begin
    reset = 1'b1;
    session = 1'b0;
    cmd_valid = 1'b0;
    cmd_word = 32'h0000_0000;
    miscompares = 0;
    n_compared = 0;
    void'($urandom(32'h3449));
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    session = 1'b1;
    send({OP_WRITE_EE, 24'h00053C}, 8'h00, 1'b0, 1'b0);
    check({7'h00, prog_mode}, 8'h00);
    check({7'h00, busy}, 8'h00);
    $display("test ignore_before_enable done");
    send({OP_ENABLE, ENABLE_ECHO, 16'h0000}, 8'h00, 1'b0, 1'b1);
    check({7'h00, prog_mode}, 8'h01);
    $display("test enable done");
    send({OP_ENABLE, SUB_ERASE, 21'h000000}, 8'h00, 1'b0, 1'b0);
    check({7'h00, busy}, 8'h01);
    wait_idle();
    rd({OP_READ_EE, 24'h000500}, ERASED);
    rd({OP_READ_PROG, 24'h000000}, ERASED);
    $display("test chip_erase done");
    a = 9'($urandom);
    v = 8'($urandom);
    w = ~v;
    send({OP_WRITE_EE, 7'h00, a[8], a[7:0], v}, 8'h00, 1'b0, 1'b0);
    rd({OP_READ_EE, 7'h00, a[8], a[7:0], 8'h00}, ERASED);
    wait_idle();
    rd({OP_READ_EE, 7'h00, a[8], a[7:0], 8'h00}, v);
    wrd({OP_WRITE_EE, 7'h00, a[8], a[7:0], w}, {OP_READ_EE, 7'h00, a[8], a[7:0], 8'h00}, w);
    $display("test eeprom done");
    p = 8'($urandom);
    wd = 6'($urandom);
    send({OP_LOAD_PAGE, 10'h000, wd, v}, 8'h00, 1'b0, 1'b0);
    send({OP_LOAD_PAGE | 8'h08, 10'h000, wd, w}, 8'h00, 1'b0, 1'b0);
    send({OP_WRITE_PAGE, 2'b00, p[7:2], p[1:0], 14'h0000}, 8'h00, 1'b0, 1'b0);
    rd({OP_READ_PROG, 2'b00, p[7:2], p[1:0], wd, 8'h00}, ERASED);
    wait_idle();
    rd({OP_READ_PROG, 2'b00, p[7:2], p[1:0], wd, 8'h00}, v);
    rd({OP_READ_PROG | 8'h08, 2'b00, p[7:2], p[1:0], wd, 8'h00}, w);
    $display("test flash_page done");
    v = 8'($urandom);
    wrd({OP_ENABLE, SUB_FUSE_LO, 8'h00, v}, {OP_READ_FUSE, 24'h000000}, v);
    wrd({OP_ENABLE, SUB_FUSE_HI, 8'h00, w}, {OP_READ_LOCK, 24'h080000}, w);
    wrd({OP_ENABLE, SUB_LOCK, 13'h0000, 2'b11, v[5:0]}, {OP_READ_LOCK, 24'h000000},
        {2'b11, v[5:0]});
    rd({OP_READ_CAL, 24'h000000}, CAL_VALUE);
    for (int k = 1; k < 4; k++) rd({OP_READ_SIG, 8'h00, 6'h00, k[1:0], 8'h00}, 8'(k));
    $display("test fuse_lock_id done");
    session = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check({7'h00, prog_mode}, 8'h00);
    $display("test session_end done");
    wrap_up();
  end
endmodule : test_serial_isp_programming_port

// >>> pkg/isp_link_if.sv
/*
  Pins of the serial programming link: reset line, serial clock and the two
  data lines. Assumes the programmer drives reset, clock and data-in.
*/
`timescale 1ns/1ps
interface isp_link_if;
  logic rst_n;
  logic sck;
  logic mosi;
  logic miso;
  modport programmer (output rst_n, output sck, output mosi, input miso);
  modport target     (input rst_n, input sck, input mosi, output miso);
endinterface : isp_link_if

// >>> pkg/isp_pkg.sv
/*
  Constants shared by both ends of the serial in-system programming link:
  instruction codes, memory sizes and the write and erase wait times.
  Assumes a 50 MHz system clock on both ends.
*/
package isp_pkg;
  localparam int          CLK_HZ           = 50_000_000;
  localparam int          CLK_NS           = 1_000_000_000 / CLK_HZ;
  localparam logic [7:0]  OP_ENABLE        = 8'hAC;
  localparam logic [7:0]  ENABLE_ECHO      = 8'h53;
  localparam logic [2:0]  SUB_ERASE        = 3'h4;
  localparam logic [2:0]  SUB_LOCK         = 3'h7;
  localparam logic [7:0]  SUB_FUSE_LO      = 8'hA0;
  localparam logic [7:0]  SUB_FUSE_HI      = 8'hA8;
  localparam logic [7:0]  OP_READ_PROG     = 8'h20;
  localparam logic [7:0]  OP_LOAD_PAGE     = 8'h40;
  localparam logic [7:0]  OP_WRITE_PAGE    = 8'h4C;
  localparam logic [7:0]  OP_READ_EE       = 8'hA0;
  localparam logic [7:0]  OP_WRITE_EE      = 8'hC0;
  localparam logic [7:0]  OP_READ_LOCK     = 8'h58;
  localparam logic [7:0]  OP_READ_FUSE     = 8'h50;
  localparam logic [7:0]  OP_READ_SIG      = 8'h30;
  localparam logic [7:0]  OP_READ_CAL      = 8'h38;
  localparam logic [7:0]  H_BIT_MASK       = 8'hF7;
  localparam logic [7:0]  ERASED           = 8'hFF;
  localparam int          PAGE_WORD_BITS   = 6;
  localparam int          PAGE_BITS        = 8;
  localparam int          FLASH_WORD_BITS  = PAGE_WORD_BITS + PAGE_BITS;
  localparam int          EE_ADDR_BITS     = 9;
  localparam int          FLASH_WAIT_US    = 4500;
  localparam int          EE_WAIT_US       = 9000;
  localparam int          ERASE_WAIT_US    = 9000;
  localparam int          FLASH_WAIT_CYC   = FLASH_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int          EE_WAIT_CYC      = EE_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int          ERASE_WAIT_CYC   = ERASE_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int          POWERUP_WAIT_US  = 20000;
  localparam int          POWERUP_WAIT_CYC = POWERUP_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int          SCK_HALF_CYC     = 4;
  localparam int          RESET_PULSE_CYC  = 4;
  localparam logic [7:0]  FUSE_LO_RESET    = 8'hE1;
  localparam logic [7:0]  FUSE_HI_RESET    = 8'h99;
  localparam logic [7:0]  LOCK_RESET       = 8'hFF;
  localparam logic [7:0]  CAL_VALUE        = 8'hA5;
endpackage : isp_pkg
